//--- shared/tick_timer_pkg.sv
// Purpose: Constants and types shared by the periodic tick timer.
// Assumes: APB with 32-bit data, one word per register.
// Notes:   Offsets are byte addresses.
package tick_timer_pkg;
   localparam logic [11:0] OFF_COUNT_VALUE    = 12'h000;
   localparam logic [11:0] OFF_CONTROL_STATUS = 12'h004;
   localparam logic [11:0] OFF_IRQ_STATUS     = 12'h008;
   localparam logic [11:0] OFF_IRQ_MASK       = 12'h00C;
   localparam logic [11:0] OFF_POWER_MODE     = 12'h010;

   localparam int unsigned BIT_ROLLOVER  = 5;
   localparam int unsigned BIT_IRQ_EN    = 4;
   localparam int unsigned BIT_COUNT_EN  = 3;

   localparam logic [7:0] RST_COUNT_VALUE    = 8'h00;
   localparam logic [7:0] RST_CONTROL_STATUS = 8'h00;
   localparam logic [1:0] RST_POWER_MODE     = 2'h0;
   localparam logic [7:0] PRESCALE_RESET     = 8'h00;
   localparam logic [7:0] COUNT_MAX          = 8'hFF;

   typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_HALT} power_mode_e;

   typedef struct packed {
      logic       irq_enable;
      logic       count_enable;
      logic [2:0] divider_select;
   } tick_ctrl_s;
endpackage

//--- hw/tick_prescaler.sv
// Purpose: Power-of-two prescaler producing one-cycle ticks.
// Assumes: Single pclk domain.
// Notes:   Division is 2 to the power of select plus one.
`timescale 1ns/10ps
module tick_prescaler
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] divider_select,
   // Tick out
   output logic            tick
);
   import tick_timer_pkg::*;

   logic [7:0] div_q;
   logic [7:0] mask;

   // Low bits that must all be one for the chosen factor
   assign mask = 8'(({1'b0, 8'hFF} << ({1'b0, divider_select} + 4'h1)) >> 9'h000) ^ 8'hFF;
   assign tick = run && ((div_q & mask) == mask); // [RULE9]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_q <= PRESCALE_RESET;
      else if (!run)
         div_q <= PRESCALE_RESET; // [RULE7]
      else
         div_q <= div_q + 8'h01; // [RULE8]
   end
endmodule

//--- hw/periodic_tick_timer.sv
// Purpose: 8-bit free-running tick counter with prescaler and APB registers.
// Assumes: APB slave, zero wait states, pclk at 25 MHz.
// Notes:   Interrupt via rollover flag and enable, or sticky status and mask; level output.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps

// Overview of operation
// [RULE1] With count enable set the counter counts up from its held value on each prescaler tick.
// [RULE2] A wrap from FFh to 00h sets the rollover flag.
// [RULE3] An interrupt request stands while rollover flag and its enable are both set.
// [RULE4] Software may write the counter at any time and counting continues from that value.
// [RULE5] Reading the control/status register clears the rollover flag; only hardware sets it.
// [RULE6] Writes to the rollover flag position leave it unchanged.
// [RULE7] With count enable clear the counter is frozen and the prescaler held in reset.
// [RULE8] With count enable set and the mode not halt, both prescaler and counter run.
// [RULE9] The divider select code n divides the clock by two to the power n plus one.
// [RULE10] The top two control/status bits always read as zero.
// [RULE11] Wait mode leaves the counter running; halt mode stops it.
// [RULE12] Interrupt enable, count enable and divider select read back as written.
// [RULE13] A rollover in the same cycle as a status read leaves the flag set.
module periodic_tick_timer
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Interrupt
   output logic             irq
);
   import tick_timer_pkg::*;

   logic [7:0]  count_q;
   tick_ctrl_s  ctrl_q;
   logic        rollover_q;
   logic        irq_status_q;
   logic        irq_mask_q;
   power_mode_e mode_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic        access;
   logic        wr;
   logic        rd;
   logic        run;
   logic        tick;
   logic        wrap;
   logic        lane0;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = hit(a, OFF_COUNT_VALUE) || hit(a, OFF_CONTROL_STATUS) ||
               hit(a, OFF_IRQ_STATUS) || hit(a, OFF_IRQ_MASK) ||
               hit(a, OFF_POWER_MODE);
   endfunction

   assign access  = psel && penable;
   assign wr      = access && pwrite && mapped(paddr);
   assign rd      = access && !pwrite && mapped(paddr);
   assign lane0   = pstrb[0];
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   // Halt stops counting, wait does not
   assign run  = ctrl_q.count_enable && (mode_q != MODE_HALT); // [RULE11] [RULE8]
   assign wrap = tick && (count_q == COUNT_MAX);

   tick_prescaler u_prescaler
   (
      .pclk           (pclk),
      .presetn        (presetn),
      .run            (run),
      .divider_select (ctrl_q.divider_select),
      .tick           (tick)
   );

   // Counter value
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_q <= RST_COUNT_VALUE;
      else if (wr && lane0 && hit(paddr, OFF_COUNT_VALUE))
         count_q <= pwdata[7:0]; // [RULE4]
      else if (tick)
         count_q <= count_q + 8'h01; // [RULE1]
   end

   // Control fields
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= tick_ctrl_s'(RST_CONTROL_STATUS[4:0]);
      else if (wr && lane0 && hit(paddr, OFF_CONTROL_STATUS))
         ctrl_q <= tick_ctrl_s'(pwdata[4:0]); // [RULE12]
   end

   // Rollover flag: set wins over read clear, writes ignored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rollover_q <= 1'b0;
      else if (wrap)
         rollover_q <= 1'b1; // [RULE2] [RULE13] [RULE6]
      else if (rd && hit(paddr, OFF_CONTROL_STATUS))
         rollover_q <= 1'b0; // [RULE5]
   end

   // Sticky interrupt status, write one to clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status_q <= 1'b0;
      else if (wrap)
         irq_status_q <= 1'b1;
      else if (wr && lane0 && hit(paddr, OFF_IRQ_STATUS) && pwdata[BIT_ROLLOVER])
         irq_status_q <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask_q <= 1'b0;
      else if (wr && lane0 && hit(paddr, OFF_IRQ_MASK))
         irq_mask_q <= pwdata[BIT_ROLLOVER];
   end

   // Power mode of the surrounding CPU
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_q <= power_mode_e'(RST_POWER_MODE);
      else if (wr && lane0 && hit(paddr, OFF_POWER_MODE))
      begin
         case (pwdata[1:0])
            2'h1:    mode_q <= MODE_WAIT;
            2'h2:    mode_q <= MODE_HALT;
            default: mode_q <= MODE_RUN;
         endcase
      end
   end

   // Level request: flag with enable, or sticky bit with mask
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= (rollover_q && ctrl_q.irq_enable) || (irq_status_q && irq_mask_q); // [RULE3]
   end

   // Read data and error response
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pslverr_q <= psel && !penable && !mapped(paddr);
         if (psel && !penable && !pwrite)
         begin
            case (paddr)
               OFF_COUNT_VALUE:
                  prdata_q <= {24'h000000, count_q};
               OFF_CONTROL_STATUS:
                  prdata_q <= {24'h000000, 2'h0, rollover_q, ctrl_q}; // [RULE10]
               OFF_IRQ_STATUS:
                  prdata_q <= {26'h0000000, irq_status_q, 5'h00};
               OFF_IRQ_MASK:
                  prdata_q <= {26'h0000000, irq_mask_q, 5'h00};
               OFF_POWER_MODE:
                  prdata_q <= {30'h00000000, 2'(mode_q)};
               default:
                  prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

//--- verif/periodic_tick_timer_checker.sv
// Purpose: Port assertions for the tick timer.
// Assumes: Zero wait state APB.
// Notes:   Tracks written control, mask and mode.
`timescale 1ns/10ps
module periodic_tick_timer_checker
   import tick_timer_pkg::*;
(
   // APB
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Interrupt
   input wire logic        irq
);
   logic [4:0] ctrl_q;
   logic       mask_q;
   logic       halt_q;
   logic       wr;
   logic       rd_s;
   logic       rd_c;
   assign wr = psel && penable && pwrite && pstrb[0];
   assign rd_s = psel && penable && !pwrite && paddr == OFF_CONTROL_STATUS;
   assign rd_c = psel && penable && !pwrite && paddr == OFF_COUNT_VALUE;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ctrl_q <= 5'h00;
         mask_q <= 1'h0;
         halt_q <= 1'h0;
      end
      else if (wr && paddr == OFF_CONTROL_STATUS)
         ctrl_q <= pwdata[4:0];
      else if (wr && paddr == OFF_IRQ_MASK)
         mask_q <= pwdata[5];
      else if (wr && paddr == OFF_POWER_MODE)
         halt_q <= pwdata[1:0] == 2'h2;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_reserved_zero: assert property (rd_s |-> prdata[7:6] == 2'h0)
      else $error("reserved bits set");
   chk_ctrl_readback: assert property (rd_s |-> prdata[4:0] == ctrl_q)
      else $error("control readback wrong");
   chk_irq_raised: assert property (rd_s && prdata[5] && prdata[4] |-> irq)
      else $error("irq missing");
   chk_irq_quiet: assert property (rd_s && !prdata[4] && !mask_q |-> !irq)
      else $error("irq without cause");
   chk_flag_cleared: assert property (rd_s && prdata[5] && !ctrl_q[3] ##2 rd_s |-> !prdata[5])
      else $error("flag not cleared");
   chk_count_frozen: assert property (rd_c && !ctrl_q[3] ##2 rd_c |->
      prdata[7:0] == $past(prdata[7:0], 2))
      else $error("count moved while off");
   chk_count_write: assert property (wr && paddr == OFF_COUNT_VALUE ##2 rd_c |->
      prdata[7:0] - $past(pwdata[7:0], 2) <= 8'h01)
      else $error("count write lost");
   chk_count_step: assert property (rd_c && ctrl_q[3] && ctrl_q[2:0] == 3'h0 && !halt_q
      ##2 rd_c |-> prdata[7:0] == $past(prdata[7:0], 2) + 8'h01)
      else $error("count step wrong");
   chk_ready_high: assert property (psel && penable |-> pready)
      else $error("wait state inserted");
   cover property (rd_s && prdata[5]);
   cover property (rd_c && halt_q);
   cover property (irq);
   cover property (psel && penable && pslverr);
endmodule
bind periodic_tick_timer periodic_tick_timer_checker u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq);

//--- verif/periodic_tick_timer_tb.sv
// Purpose: Self-checking bench for the tick timer.
// Assumes: Zero wait state APB slave.
// Notes:   Expected counts from divider arithmetic.
`timescale 1ns/10ps
module periodic_tick_timer_tb;
   import tick_timer_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, r;
   logic [3:0]  pstrb;
   int          num_errors, total_checks, cycles, seed;
   periodic_tick_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq);
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
   endtask
   task automatic idle(input int n);
      psel <= 1'h0;
      penable <= 1'h0;
      repeat (n) @(posedge pclk);
   endtask
   initial
   begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         num_errors++;
         test_done();
      end
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
      seed = 70838;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, OFF_CONTROL_STATUS, 32'h0);
      chk("csr reset", 32'h0, rd);
      for (int s = 0; s < 8; s++)
      begin
         r = $random(seed) & 32'h10;
         apb(1'h1, OFF_CONTROL_STATUS, 32'h0);
         apb(1'h1, OFF_COUNT_VALUE, 32'h0);
         apb(1'h1, OFF_CONTROL_STATUS, r | 32'h8 | s);
         idle(6 << s);
         apb(1'h0, OFF_COUNT_VALUE, 32'h0);
         chk("count", 32'h3, rd);
         apb(1'h0, OFF_CONTROL_STATUS, 32'h0);
         chk("csr", r | 32'h8 | s, rd);
      end
      apb(1'h1, OFF_CONTROL_STATUS, 32'h0);
      idle(600);
      repeat (2)
      begin
         apb(1'h0, OFF_COUNT_VALUE, 32'h0);
         chk("frozen", 32'h3, rd);
      end
      apb(1'h1, OFF_COUNT_VALUE, 32'hFE);
      apb(1'h1, OFF_CONTROL_STATUS, 32'h18);
      idle(6);
      chk("irq on", 32'h1, irq);
      apb(1'h1, OFF_CONTROL_STATUS, 32'hD0);
      apb(1'h0, OFF_CONTROL_STATUS, 32'h0);
      chk("flag set", 32'h30, rd);
      apb(1'h0, OFF_CONTROL_STATUS, 32'h0);
      chk("flag clear", 32'h10, rd);
      apb(1'h1, OFF_CONTROL_STATUS, 32'h08);
      apb(1'h0, OFF_IRQ_STATUS, 32'h0);
      chk("sticky", 32'h20, rd);
      chk("irq masked", 32'h0, irq);
      apb(1'h1, OFF_IRQ_MASK, 32'h20);
      idle(2);
      chk("irq unmasked", 32'h1, irq);
      apb(1'h1, OFF_IRQ_STATUS, 32'h20);
      idle(2);
      chk("irq cleared", 32'h0, irq);
      r = $random(seed) & 32'hFF;
      apb(1'h1, OFF_POWER_MODE, 32'h2);
      apb(1'h1, OFF_COUNT_VALUE, r);
      apb(1'h0, OFF_COUNT_VALUE, 32'h0);
      chk("written", r, rd);
      idle(20);
      apb(1'h0, OFF_COUNT_VALUE, 32'h0);
      chk("halted", r, rd);
      apb(1'h1, OFF_POWER_MODE, 32'h1);
      idle(19);
      apb(1'h0, OFF_COUNT_VALUE, 32'h0);
      chk("wait runs", (r + 32'h9) & 32'hFF, rd);
      apb(1'h0, OFF_COUNT_VALUE, 32'h0);
      apb(1'h0, 12'h020, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      idle(2);
      test_done();
   end
endmodule
